// file: shared/sgp_map.svh
// register indices, pin masks and reset values of the six-port gpio bank
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH
`define SGP_IDX_PA_DATA  6'h00
`define SGP_IDX_PA_DIR   6'h01
`define SGP_IDX_PA_OPT   6'h02
`define SGP_IDX_PB_DATA  6'h03
`define SGP_IDX_PB_DIR   6'h04
`define SGP_IDX_PB_OPT   6'h05
`define SGP_IDX_PC_DATA  6'h06
`define SGP_IDX_PC_DIR   6'h07
`define SGP_IDX_PC_OPT   6'h08
`define SGP_IDX_PD_DATA  6'h09
`define SGP_IDX_PD_DIR   6'h0a
`define SGP_IDX_PD_OPT   6'h0b
`define SGP_IDX_PE_DATA  6'h0c
`define SGP_IDX_PE_DIR   6'h0d
`define SGP_IDX_PE_OPT   6'h0e
`define SGP_IDX_PF_DATA  6'h0f
`define SGP_IDX_PF_DIR   6'h10
`define SGP_IDX_PF_OPT   6'h11
`define SGP_IDX_IRQ_STAT 6'h20
`define SGP_IDX_IRQ_MASK 6'h21
`define SGP_IDX_STRIDE   3
`define SGP_IDX_DIR_OFS  1
`define SGP_IDX_OPT_OFS  2
`define SGP_IDX_HI       7
`define SGP_IDX_LO       2
`define SGP_PORTS        6
`define SGP_PORT_W       8
`define SGP_PORT_C       2
`define SGP_PORT_D       3
`define SGP_RST_BYTE     8'h00
`define SGP_ALL_BYTE     8'hff
`define SGP_RST_WORD     32'h0000_0000
`define SGP_RST_PINS     48'h0000_0000_0000
`define SGP_BOND_ALL     48'hffff_ffff_ffff
`define SGP_WPU_CAP      48'hfb_ff_ff_ff_7f_37
`define SGP_INT_CAP      48'h07_00_00_00_ff_0f
`define SGP_ANA_CAP      48'h39_00_ff_a3_00_00
`define SGP_TRUE_OD      48'h00_00_00_00_00_c0
`define SGP_PE2_PIN      48'h00_04_00_00_00_00
`define SGP_EI0_PINS     48'h00_00_00_00_00_0f
`define SGP_EI1_PINS     48'h07_00_00_00_00_00
`define SGP_EI2_PINS     48'h00_00_00_00_0f_00
`define SGP_EI3_PINS     48'h00_00_00_00_f0_00
`define SGP_BIT_TW_SDA   6
`define SGP_BIT_TW_SCL   7
`define SGP_BIT_TX       32
`define SGP_BIT_RX       33
`define SGP_BIT_PE2      34
`define SGP_RST_IRQ      4'h0
`define SGP_AGE_FULL     2'h3
`endif

// file: shared/sgp_pkg.sv
// types of the six-port gpio bank
package sgp_pkg;
   typedef logic [11:0]      sgp_addr_t;
   typedef logic [47:0]      sgp_pins_t;
   typedef logic [5:0][7:0]  sgp_bank_t;
   typedef enum logic [1:0] {
      SGP_IDLE = 2'b01,
      SGP_RESP = 2'b10
   } sgp_phase_e;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      sgp_addr_t   paddr;
      logic [31:0] pwdata;
   } sgp_apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sgp_apb_rsp_s;
   typedef struct packed {
      logic tw_en;
      logic tw_sda_low;
      logic tw_scl_low;
      logic tx_en;
      logic tx_data;
   } sgp_alt_ctl_s;
   typedef struct packed {
      logic two_wire_data_alt;
      logic two_wire_clock_alt;
      logic async_serial_rx_alt;
   } sgp_alt_in_s;
   typedef struct packed {
      sgp_phase_e   phase;
      sgp_bank_t    dat;
      sgp_bank_t    dir;
      sgp_bank_t    opt;
      sgp_pins_t    sync_a;
      sgp_pins_t    sync_b;
      sgp_pins_t    prev;
      sgp_pins_t    pad_out;
      sgp_pins_t    pad_oe;
      sgp_pins_t    pad_pu;
      logic [3:0]   irq_st;
      logic [3:0]   irq_mk;
      logic         irq;
      sgp_apb_rsp_s rsp;
      sgp_alt_in_s  alt;
      logic         boot;
      logic [1:0]   age;
   } sgp_state_s;
endpackage

// file: src/sgp_bank.sv
// six-port gpio bank with apb registers, pad control and pin interrupts
// Functional notes
// - A data register read returns the stored bit for outputs and the pin level for inputs.
// - After reset every unbonded pad is an input with its pull-up on.
// - Each port has at most eight pads, one per bit of its three byte registers.
// - The pull-up of port E bit 2 is always on, whatever software selects.
// - Interrupt pins give a pull-up interrupt input if pull-up capable, else a floating one.
// - Port A bits 6 and 7 are true open drain and can only pull low or release.
// - Reset clears every data, direction and option register so all pins start as inputs.
// - Ports decode as triples data, direction, option, port A lowest and port F last.
// - Pins start as port bits; A6/A7 also carry two-wire data/clock, E0/E1 serial tx/rx.
// - Inputs may be floating, pull-up, interrupt or analog; outputs open drain or push-pull.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "sgp_map.svh"
module sgp_bank
#(
   parameter sgp_pkg::sgp_pins_t BONDED_PADS = `SGP_BOND_ALL
)
(
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire sgp_pkg::sgp_apb_req_s APB_REQ,
   output sgp_pkg::sgp_apb_rsp_s      APB_RSP,
   input  wire sgp_pkg::sgp_pins_t    PAD_IN,
   output sgp_pkg::sgp_pins_t         PAD_OUT,
   output sgp_pkg::sgp_pins_t         PAD_OE,
   output sgp_pkg::sgp_pins_t         PAD_PU,
   input  wire sgp_pkg::sgp_pins_t    ANALOG_SEL,
   input  wire sgp_pkg::sgp_alt_ctl_s ALT_CTL,
   output sgp_pkg::sgp_alt_in_s       ALT_IN,
   output logic                       IRQ
);

   // ----------------------------------------
   // state and reset value
   // ----------------------------------------
   localparam sgp_pkg::sgp_state_s RST_ST = '{
      phase   : sgp_pkg::SGP_IDLE,
      pad_pu  : ~BONDED_PADS | `SGP_PE2_PIN,
      boot    : 1'b1,
      default : '0
   };

   sgp_pkg::sgp_state_s st_q;
   sgp_pkg::sgp_state_s st_d;
   logic [5:0]          idx;
   logic                hit;
   logic                acc;
   sgp_pkg::sgp_pins_t  dirf;
   sgp_pkg::sgp_pins_t  optf;
   sgp_pkg::sgp_pins_t  datf;
   sgp_pkg::sgp_pins_t  ana;
   sgp_pkg::sgp_pins_t  pp;
   sgp_pkg::sgp_pins_t  ev;
   logic [3:0]          ev_v;
   logic [3:0]          clr;
   logic [7:0]          wb;

   // ----------------------------------------
   // address decode helpers
   // ----------------------------------------
   function automatic logic [5:0] sgp_index(input sgp_pkg::sgp_addr_t a);
      return a[`SGP_IDX_HI:`SGP_IDX_LO];
   endfunction

   function automatic logic sgp_mapped(input sgp_pkg::sgp_addr_t a);
      logic [5:0] i;
      i = sgp_index(a);
      return ~|a[`SGP_IDX_LO-1:0] && ~|(a >> (`SGP_IDX_HI + 1))
         && (i <= `SGP_IDX_PF_OPT || i == `SGP_IDX_IRQ_STAT
         || i == `SGP_IDX_IRQ_MASK);
   endfunction

   function automatic logic [5:0] sgp_reg(input int p, input int ofs);
      return 6'(`SGP_IDX_PA_DATA + p * `SGP_IDX_STRIDE + ofs);
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_d = st_q;
      idx  = sgp_index(APB_REQ.paddr);
      hit  = sgp_mapped(APB_REQ.paddr);
      acc  = APB_REQ.psel & APB_REQ.penable;
      wb   = APB_REQ.pwdata[`SGP_PORT_W-1:0];
      dirf = st_q.dir;
      optf = st_q.opt;
      datf = st_q.dat;
      clr  = `SGP_RST_IRQ;

      // pad input synchroniser
      st_d.sync_a = PAD_IN;
      st_d.sync_b = st_q.sync_a;
      st_d.prev   = st_q.sync_b;
      st_d.boot   = 1'b0;
      if (st_q.age != `SGP_AGE_FULL)
      begin
         st_d.age = st_q.age + 2'(1);
      end

      // apb slave
      st_d.rsp.pready  = 1'b0;
      st_d.rsp.pslverr = 1'b0;
      case (st_q.phase)
         sgp_pkg::SGP_IDLE:
         begin
            if (acc)
            begin
               st_d.phase       = sgp_pkg::SGP_RESP;
               st_d.rsp.pready  = 1'b1;
               st_d.rsp.pslverr = ~hit;
               st_d.rsp.prdata  = `SGP_RST_WORD;
               if (hit && !APB_REQ.pwrite)
               begin
                  for (int p = 0; p < `SGP_PORTS; p++)
                  begin
                     if (idx == sgp_reg(p, 0))
                     begin
                        st_d.rsp.prdata[`SGP_PORT_W-1:0] =
                           (st_q.dat[p] & st_q.dir[p])
                           | (st_q.sync_b[p*`SGP_PORT_W +: `SGP_PORT_W] & ~st_q.dir[p]);
                     end
                     else if (idx == sgp_reg(p, `SGP_IDX_DIR_OFS))
                     begin
                        st_d.rsp.prdata[`SGP_PORT_W-1:0] = st_q.dir[p];
                     end
                     else if (idx == sgp_reg(p, `SGP_IDX_OPT_OFS))
                     begin
                        st_d.rsp.prdata[`SGP_PORT_W-1:0] = st_q.opt[p];
                     end
                  end
                  if (idx == `SGP_IDX_IRQ_STAT)
                  begin
                     st_d.rsp.prdata[3:0] = st_q.irq_st;
                  end
                  else if (idx == `SGP_IDX_IRQ_MASK)
                  begin
                     st_d.rsp.prdata[3:0] = st_q.irq_mk;
                  end
               end
            end
         end
         sgp_pkg::SGP_RESP:
         begin
            st_d.phase = sgp_pkg::SGP_IDLE;
            if (acc && hit && APB_REQ.pwrite)
            begin
               for (int p = 0; p < `SGP_PORTS; p++)
               begin
                  if (idx == sgp_reg(p, 0))
                  begin
                     st_d.dat[p] = wb & BONDED_PADS[p*`SGP_PORT_W +: `SGP_PORT_W];
                  end
                  else if (idx == sgp_reg(p, `SGP_IDX_DIR_OFS))
                  begin
                     st_d.dir[p] = wb & BONDED_PADS[p*`SGP_PORT_W +: `SGP_PORT_W];
                  end
                  else if (idx == sgp_reg(p, `SGP_IDX_OPT_OFS))
                  begin
                     st_d.opt[p] = wb & BONDED_PADS[p*`SGP_PORT_W +: `SGP_PORT_W];
                  end
               end
               if (idx == `SGP_IDX_IRQ_STAT)
               begin
                  clr = APB_REQ.pwdata[3:0];
               end
               else if (idx == `SGP_IDX_IRQ_MASK)
               begin
                  st_d.irq_mk = APB_REQ.pwdata[3:0];
               end
            end
         end
         default:
         begin
            st_d.phase = sgp_pkg::SGP_IDLE;
         end
      endcase

      ana = ANALOG_SEL & `SGP_ANA_CAP & ~dirf;
      pp  = dirf & optf & ~`SGP_TRUE_OD;
      st_d.pad_oe  = BONDED_PADS & (pp | (dirf & ~pp & ~datf));
      st_d.pad_out = BONDED_PADS & pp & datf;
      if (ALT_CTL.tw_en)
      begin
         st_d.pad_oe[`SGP_BIT_TW_SDA]  = ALT_CTL.tw_sda_low;
         st_d.pad_oe[`SGP_BIT_TW_SCL]  = ALT_CTL.tw_scl_low;
         st_d.pad_out[`SGP_BIT_TW_SDA] = 1'b0;
         st_d.pad_out[`SGP_BIT_TW_SCL] = 1'b0;
      end
      if (ALT_CTL.tx_en)
      begin
         st_d.pad_oe[`SGP_BIT_TX]  = BONDED_PADS[`SGP_BIT_TX];
         st_d.pad_out[`SGP_BIT_TX] = BONDED_PADS[`SGP_BIT_TX] & ALT_CTL.tx_data;
      end
      st_d.pad_out = st_d.pad_out & ~`SGP_TRUE_OD;
      st_d.pad_pu = ~BONDED_PADS | `SGP_PE2_PIN
         | (~dirf & optf & `SGP_WPU_CAP & ~ana);
      st_d.alt.two_wire_data_alt   = st_q.sync_b[`SGP_BIT_TW_SDA];
      st_d.alt.two_wire_clock_alt  = st_q.sync_b[`SGP_BIT_TW_SCL];
      st_d.alt.async_serial_rx_alt = st_q.sync_b[`SGP_BIT_RX];

      ev = `SGP_INT_CAP & BONDED_PADS & ~dirf & optf & ~ana
         & st_q.prev & ~st_q.sync_b;
      ev_v[0] = |(ev & `SGP_EI0_PINS);
      ev_v[1] = |(ev & `SGP_EI1_PINS);
      ev_v[2] = |(ev & `SGP_EI2_PINS);
      ev_v[3] = |(ev & `SGP_EI3_PINS);
      // set wins over clear
      st_d.irq_st = (st_q.irq_st & ~clr) | ev_v;
      st_d.irq    = |(st_d.irq_st & st_d.irq_mk);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_q <= RST_ST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign APB_RSP = st_q.rsp;
   assign PAD_OUT = st_q.pad_out;
   assign PAD_OE  = st_q.pad_oe;
   assign PAD_PU  = st_q.pad_pu;
   assign ALT_IN  = st_q.alt;
   assign IRQ     = st_q.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking sgp_cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   reset_clear_a : assert property (
      st_q.boot |-> (st_q.dat == '0 && st_q.dir == '0 && st_q.opt == '0
         && PAD_OE == `SGP_RST_PINS))
      else $error("registers not cleared by reset");

   data_read_a : assert property (
      (st_q.phase == sgp_pkg::SGP_IDLE && acc && !APB_REQ.pwrite
         && idx == `SGP_IDX_PA_DATA && hit)
      |=> APB_RSP.pready ##0 APB_RSP.prdata[`SGP_PORT_W-1:0] ==
         (($past(st_q.dat[0]) & $past(st_q.dir[0]))
         | ($past(st_q.sync_b[`SGP_PORT_W-1:0]) & ~$past(st_q.dir[0]))))
      else $error("data read does not mix latch and pin");

   dir_write_a : assert property (
      (st_q.phase == sgp_pkg::SGP_RESP && acc && APB_REQ.pwrite
         && APB_REQ.paddr == {4'h0, `SGP_IDX_PB_DIR, 2'b00})
      |=> st_q.dir[1] == ($past(APB_REQ.pwdata[`SGP_PORT_W-1:0])
         & BONDED_PADS[`SGP_PORT_W +: `SGP_PORT_W]))
      else $error("port b direction write misplaced");

   unbonded_pad_a : assert property (
      ((PAD_PU | BONDED_PADS) == `SGP_BOND_ALL)
      && ((PAD_OE & ~BONDED_PADS) == `SGP_RST_PINS))
      else $error("unbonded pad not input with pull-up");

   pe2_pullup_a : assert property (PAD_PU[`SGP_BIT_PE2])
      else $error("pull-up on port e bit two released");

   open_drain_a : assert property (
      (PAD_OUT & `SGP_TRUE_OD) == `SGP_RST_PINS)
      else $error("true open drain pin driven high");

   input_dir_a : assert property (
      st_q.dir[`SGP_PORT_C] == `SGP_RST_BYTE
      |=> PAD_OE[`SGP_PORT_C*`SGP_PORT_W +: `SGP_PORT_W] == `SGP_RST_BYTE)
      else $error("input pin is driven");

   push_pull_a : assert property (
      (st_q.dir[`SGP_PORT_D] == `SGP_ALL_BYTE && st_q.opt[`SGP_PORT_D] == `SGP_ALL_BYTE)
      |=> (PAD_OE[`SGP_PORT_D*`SGP_PORT_W +: `SGP_PORT_W]
         == BONDED_PADS[`SGP_PORT_D*`SGP_PORT_W +: `SGP_PORT_W])
      ##0 (PAD_OUT[`SGP_PORT_D*`SGP_PORT_W +: `SGP_PORT_W]
         == ($past(st_q.dat[`SGP_PORT_D])
         & BONDED_PADS[`SGP_PORT_D*`SGP_PORT_W +: `SGP_PORT_W])))
      else $error("push-pull output wrong");

   pin_event_a : assert property (
      (BONDED_PADS[0] && !st_q.dir[0][0] && st_q.opt[0][0]
         && st_q.prev[0] && !st_q.sync_b[0])
      |=> st_q.irq_st[0] && (IRQ || !st_q.irq_mk[0]))
      else $error("falling edge lost its status bit");

   rx_alt_a : assert property (
      st_q.age == `SGP_AGE_FULL
      |-> ALT_IN.async_serial_rx_alt == $past(PAD_IN[`SGP_BIT_RX], 3))
      else $error("serial receive input not three cycles behind pin");

   ready_pulse_a : assert property (
      APB_RSP.pready |=> !APB_RSP.pready)
      else $error("ready held longer than one cycle");

   unmapped_err_a : assert property (
      (st_q.phase == sgp_pkg::SGP_IDLE && acc && !hit)
      |=> APB_RSP.pready && APB_RSP.pslverr && APB_RSP.prdata == `SGP_RST_WORD)
      else $error("unmapped access not refused");

   dir_read_a : assert property (
      (st_q.phase == sgp_pkg::SGP_IDLE && acc && !APB_REQ.pwrite && hit
         && idx == `SGP_IDX_PC_DIR)
      |=> APB_RSP.prdata[`SGP_PORT_W-1:0] == $past(st_q.dir[`SGP_PORT_C]))
      else $error("port c direction read wrong");

   opt_write_a : assert property (
      (st_q.phase == sgp_pkg::SGP_RESP && acc && APB_REQ.pwrite
         && APB_REQ.paddr == {4'h0, `SGP_IDX_PF_OPT, 2'b00})
      |=> st_q.opt[`SGP_PORTS-1] == ($past(APB_REQ.pwdata[`SGP_PORT_W-1:0])
         & BONDED_PADS[(`SGP_PORTS-1)*`SGP_PORT_W +: `SGP_PORT_W]))
      else $error("port f option write misplaced");

   unbonded_reg_a : assert property (
      ((st_q.dat | st_q.dir | st_q.opt) & ~BONDED_PADS) == `SGP_RST_PINS)
      else $error("register bit of unbonded pad set");

   analog_pullup_a : assert property (
      (PAD_PU & $past(ana) & BONDED_PADS) == `SGP_RST_PINS)
      else $error("pull-up left on analog input");

   open_drain_out_a : assert property (
      (st_q.dir[`SGP_PORT_C] == `SGP_ALL_BYTE && st_q.opt[`SGP_PORT_C] == `SGP_RST_BYTE)
      |=> PAD_OUT[`SGP_PORT_C*`SGP_PORT_W +: `SGP_PORT_W] == `SGP_RST_BYTE
         && PAD_OE[`SGP_PORT_C*`SGP_PORT_W +: `SGP_PORT_W]
         == (~$past(st_q.dat[`SGP_PORT_C])
         & BONDED_PADS[`SGP_PORT_C*`SGP_PORT_W +: `SGP_PORT_W]))
      else $error("open drain output drives high");

   tw_override_a : assert property (
      ALT_CTL.tw_en
      |=> PAD_OE[`SGP_BIT_TW_SDA] == $past(ALT_CTL.tw_sda_low)
         && PAD_OE[`SGP_BIT_TW_SCL] == $past(ALT_CTL.tw_scl_low)
         && !PAD_OUT[`SGP_BIT_TW_SDA] && !PAD_OUT[`SGP_BIT_TW_SCL])
      else $error("two-wire lines not released to the bus");

   tx_drive_a : assert property (
      ALT_CTL.tx_en
      |=> PAD_OE[`SGP_BIT_TX] == BONDED_PADS[`SGP_BIT_TX]
         && PAD_OUT[`SGP_BIT_TX] == ($past(ALT_CTL.tx_data) & BONDED_PADS[`SGP_BIT_TX]))
      else $error("serial transmit pin not driven");

   irq_level_a : assert property (
      IRQ == |(st_q.irq_st & st_q.irq_mk))
      else $error("interrupt line does not follow masked status");

   status_clear_a : assert property (
      (st_q.phase == sgp_pkg::SGP_RESP && acc && hit && APB_REQ.pwrite
         && idx == `SGP_IDX_IRQ_STAT && ev_v == `SGP_RST_IRQ)
      |=> (st_q.irq_st & $past(APB_REQ.pwdata[3:0])) == `SGP_RST_IRQ)
      else $error("written one did not clear status");

   set_wins_a : assert property (
      ev_v != `SGP_RST_IRQ |=> (st_q.irq_st & $past(ev_v)) == $past(ev_v))
      else $error("pin event lost against clear");

   mask_write_a : assert property (
      (st_q.phase == sgp_pkg::SGP_RESP && acc && hit && APB_REQ.pwrite
         && idx == `SGP_IDX_IRQ_MASK)
      |=> st_q.irq_mk == $past(APB_REQ.pwdata[3:0]))
      else $error("interrupt mask write lost");

endmodule

// file: tb/sgp_pin_model.sv
// external pin model: drive, pull-up and floating levels of the 48 pads
`timescale 1ns/1ns
module sgp_pin_model
(
   input  wire logic               clk,
   input  wire sgp_pkg::sgp_pins_t pad_out,
   input  wire sgp_pkg::sgp_pins_t pad_oe,
   input  wire sgp_pkg::sgp_pins_t pad_pu,
   input  wire sgp_pkg::sgp_pins_t ext_val,
   input  wire sgp_pkg::sgp_pins_t ext_en,
   output sgp_pkg::sgp_pins_t      pad_in
);
   sgp_pkg::sgp_pins_t last_q = 48'h0;
   always @(posedge clk)
   begin
      last_q <= pad_in;
   end
   always_comb
   begin
      for (int i = 0; i < 48; i++)
      begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else if (pad_pu[i])
            pad_in[i] = 1'b1;
         else
            pad_in[i] = ~last_q[i];
      end
   end
endmodule

// file: tb/sgp_bank_bench.sv
// self-checking bench of the six-port gpio bank
`timescale 1ns/1ns
`include "sgp_map.svh"
module sgp_bank_bench;
   localparam sgp_pkg::sgp_pins_t BOND = 48'h7fff_ffff_ffff;
   logic                  clk;
   logic                  rst_n;
   logic                  irq;
   logic                  err;
   logic [31:0]           rdat;
   logic [7:0]            d;
   logic [7:0]            r;
   logic [7:0]            o;
   sgp_pkg::sgp_apb_req_s req;
   sgp_pkg::sgp_apb_rsp_s rsp;
   sgp_pkg::sgp_alt_ctl_s alt_ctl;
   sgp_pkg::sgp_alt_in_s  alt_in;
   sgp_pkg::sgp_pins_t    pad_in, pad_out, pad_oe, pad_pu, ana, ext_val, ext_en;
   sgp_pkg::sgp_pins_t    dat_m, dir_m, opt_m;
   int                    fails, check_count, cycles, seed;

   sgp_bank #(.BONDED_PADS(BOND)) i_sgp_bank
   (
      .CLK        (clk),
      .RST_N      (rst_n),
      .APB_REQ    (req),
      .APB_RSP    (rsp),
      .PAD_IN     (pad_in),
      .PAD_OUT    (pad_out),
      .PAD_OE     (pad_oe),
      .PAD_PU     (pad_pu),
      .ANALOG_SEL (ana),
      .ALT_CTL    (alt_ctl),
      .ALT_IN     (alt_in),
      .IRQ        (irq)
   );
   sgp_pin_model i_sgp_pin_model
   (
      .clk     (clk),
      .pad_out (pad_out),
      .pad_oe  (pad_oe),
      .pad_pu  (pad_pu),
      .ext_val (ext_val),
      .ext_en  (ext_en),
      .pad_in  (pad_in)
   );

   //--------------------------------------------------
   // helpers
   //--------------------------------------------------
   task automatic close_out();
      if (fails == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= wd;
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic cfg(input int p, input logic [7:0] dv, input logic [7:0] rv,
                      input logic [7:0] ov);
      logic [7:0] m;
      m = BOND[p*8 +: 8];
      dat_m[p*8 +: 8] = dv & m;
      dir_m[p*8 +: 8] = rv & m;
      opt_m[p*8 +: 8] = ov & m;
      apb(1'b1, 12'(12 * p), {24'h0, dv & m});
      apb(1'b1, 12'(12 * p + 4), {24'h0, rv & m});
      apb(1'b1, 12'(12 * p + 8), {24'h0, ov & m});
   endtask
   function automatic sgp_pkg::sgp_pins_t f_oe();
      return dir_m & ((opt_m & ~`SGP_TRUE_OD) | ~dat_m);
   endfunction
   function automatic sgp_pkg::sgp_pins_t f_pu(input sgp_pkg::sgp_pins_t a);
      return (~dir_m & opt_m & `SGP_WPU_CAP & ~(a & `SGP_ANA_CAP)) | ~BOND | `SGP_PE2_PIN;
   endfunction

   //--------------------------------------------------
   // clock and timeout
   //--------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         fails++;
         close_out();
      end
   end

   //--------------------------------------------------
   // main sequence
   //--------------------------------------------------
   initial
   begin
      seed = 32'hf68b40e8;
      rst_n = 1'b0;
      req = 47'h0;
      alt_ctl = 5'h0;
      ana = 48'h0;
      ext_val = 48'h0;
      ext_en = 48'hffff_ffff_ffff;
      dat_m = 48'h0;
      dir_m = 48'h0;
      opt_m = 48'h0;
      repeat (5) @(posedge clk);
      check("reset oe", pad_oe, 48'h0);
      check("reset pu", pad_pu, ~BOND | `SGP_PE2_PIN);
      @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 18; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check("reset reg", {err, rdat}, 33'h0);
      end
      ext_en <= ~`SGP_PE2_PIN;
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h030, 32'h0);
      check("pe2 pull", rdat, 32'h4);
      ext_en <= 48'hffff_ffff_ffff;
      apb(1'b0, 12'h0c0, 32'h0);
      check("unmapped", {err, rdat}, 33'h1_0000_0000);
      for (int k = 0; k < 16; k++)
      begin
         ext_val <= 48'({$random(seed), $random(seed)});
         for (int p = 0; p < 6; p++)
         begin
            d = (k == 0) ? 8'haa : 8'($random(seed));
            r = (k < 2) ? 8'hff : 8'($random(seed));
            o = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            cfg(p, d, r, o);
         end
         repeat (4) @(posedge clk);
         check("pad oe", pad_oe, f_oe());
         check("pad out", pad_out & f_oe(), dat_m & f_oe());
         check("pad pu", pad_pu, f_pu(48'h0));
         check("irq masked", irq, 1'b0);
         for (int p = 0; p < 6; p++)
         begin
            apb(1'b0, 12'(12 * p), 32'h0);
            check("data rd", rdat & BOND[p*8 +: 8],
                  ((dat_m & dir_m) | (ext_val & ~dir_m)) >> (p * 8) & BOND[p*8 +: 8]);
            apb(1'b0, 12'(12 * p + 4), 32'h0);
            check("dir rd", rdat, 32'(dir_m[p*8 +: 8]));
         end
         ana <= 48'({$random(seed), $random(seed)});
         repeat (3) @(posedge clk);
         check("analog pu", pad_pu, f_pu(ana));
         ana <= 48'h0;
      end
      cfg(0, 8'h00, 8'h00, 8'h01);
      ext_val[0] <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b1, 12'h080, 32'hf);
      apb(1'b1, 12'h084, 32'h1);
      ext_val[0] <= 1'b0;
      repeat (6) @(posedge clk);
      check("irq set", irq, 1'b1);
      apb(1'b0, 12'h080, 32'h0);
      check("irq status", rdat, 32'h1);
      apb(1'b1, 12'h084, 32'h0);
      repeat (2) @(posedge clk);
      check("irq mask", irq, 1'b0);
      apb(1'b1, 12'h084, 32'h1);
      apb(1'b1, 12'h080, 32'h1);
      repeat (2) @(posedge clk);
      check("irq clear", irq, 1'b0);
      cfg(4, 8'h00, 8'h00, 8'h00);
      ext_val[7] <= 1'b1;
      ext_val[33] <= 1'b1;
      alt_ctl <= 5'b11010;
      repeat (6) @(posedge clk);
      check("tw drive", {pad_oe[7:6], pad_oe[32], pad_out[32]}, 4'b0110);
      check("alt in", alt_in, 3'b011);
      close_out();
   end
endmodule
